// ---- design/ifm_buzzer.sv ----
// buzzer arbiter: picks the highest sounding request
`timescale 1ns/1ps
`include "ifm_consts.svh"
module ifm_buzzer
  import ifm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic tick,
  // requests
  input wire ifm_buzreq_t req,
  input wire logic interlock,
  input wire logic regional,
  // sounder
  output logic buzzerOn,
  output ifm_buzsrc_t buzzerSrc
);
  logic [2:0] blinkCnt;
  logic blink;

  // 0.4 s on / 0.4 s off from the 100 ms tick
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      blinkCnt <= 3'h0;
      blink <= 1'b0;
    end else if (!interlock) begin
      blinkCnt <= 3'h0;
      blink <= 1'b1; // restart so a new request begins sounding
    end else if (tick) begin
      if (blinkCnt == 3'(`IFM_BUZ_TICKS - 1)) begin
        blinkCnt <= 3'h0;
        blink <= !blink;
      end else begin
        blinkCnt <= blinkCnt + 3'h1;
      end
    end
  end

  // fixed priority; phone only counts in the regional convention
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      buzzerOn <= 1'b0;
      buzzerSrc <= BZ_NONE;
    end else if (req.fire) begin
      buzzerOn <= 1'b1;
      buzzerSrc <= BZ_FIRE;
    end else if (req.preWarn) begin
      buzzerOn <= 1'b1;
      buzzerSrc <= BZ_PREWARN;
    end else if (req.phone && regional) begin
      buzzerOn <= 1'b1;
      buzzerSrc <= BZ_PHONE;
    end else if (interlock) begin
      buzzerOn <= blink;
      buzzerSrc <= BZ_INTLK;
    end else if (req.fault) begin
      buzzerOn <= 1'b1;
      buzzerSrc <= BZ_FAULT;
    end else begin
      buzzerOn <= 1'b0;
      buzzerSrc <= BZ_NONE;
    end
  end
endmodule : ifm_buzzer

// ---- design/ifm_consts.svh ----
// constants for the interlock feedback monitor
`ifndef IFM_CONSTS_SVH
`define IFM_CONSTS_SVH
`define IFM_NCOMB 200
`define IFM_NSYS 1000
`define IFM_IDX_W 8
`define IFM_TYPE_STEADY 3'h0
`define IFM_TYPE_DELAY 3'h3
`define IFM_TRIG_INTLK 5'h0e
`define IFM_COND_AREA 5'h0f
`define IFM_COND_POINT 5'h10
`define IFM_COND_ANY 5'h11
`define IFM_COND_RANGE 5'h12
`define IFM_AREA_MAX 10'h3e7
`define IFM_POINT_MAX 7'h63
`define IFM_FTIME_MIN 8'h05
`define IFM_OP_ACT 3'h1
`define IFM_OP_RST 3'h2
`define IFM_OP_DIS 3'h3
`define IFM_OP_ENA 3'h4
`define IFM_REG_CTRL 8'h00
`define IFM_REG_SEL 8'h04
`define IFM_REG_CFGA 8'h08
`define IFM_REG_CFGB 8'h0c
`define IFM_REG_CMD 8'h10
`define IFM_REG_STAT 8'h14
`define IFM_REG_STAMP 8'h18
`define IFM_REG_FLT 8'h1c
`define IFM_CLK_NS 5
`define IFM_NS_PER_MS 1000000
`define IFM_TICK_MS 100
`define IFM_BUZ_MS 400
`define IFM_SEC_MS 1000
`define IFM_BUZ_TICKS (`IFM_BUZ_MS / `IFM_TICK_MS)
`define IFM_SEC_TICKS (`IFM_SEC_MS / `IFM_TICK_MS)
`endif

// ---- design/ifm_pkg.sv ----
// types shared by the interlock feedback monitor
package ifm_pkg;
  typedef struct packed {
    logic [9:0] area;
    logic [6:0] point;
  } ifm_addr_t;
  typedef struct packed {
    logic pad;
    logic faultEn;
    logic buzz;
    logic latch;
    logic [4:0] trigSel;
    logic [2:0] actType;
    logic hasIn;
    logic hasOut;
    ifm_addr_t addr;
  } ifm_cfga_t;
  typedef struct packed {
    logic [15:0] pad;
    logic [7:0] delayTime;
    logic [7:0] faultTime;
  } ifm_cfgb_t;
  typedef struct packed {
    ifm_cfga_t a;
    ifm_cfgb_t b;
  } ifm_cfg_t;
  typedef struct packed {
    logic [11:0] pad;
    logic [2:0] op;
    ifm_addr_t addr;
  } ifm_cmd_t;
  typedef struct packed {
    logic [29:0] pad;
    logic silence;
    logic regional;
  } ifm_ctrl_t;
  typedef struct packed {
    logic [25:0] pad;
    logic cfgErr;
    logic anyFault;
    logic fault;
    logic disabled;
    logic inOn;
    logic outOn;
  } ifm_stat_t;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
  } ifm_tod_t;
  typedef struct packed {
    logic [9:0] pad;
    ifm_tod_t inAt;
    ifm_tod_t outAt;
  } ifm_stampw_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ifm_req_t;
  typedef struct packed {
    logic [4:0] code;
    ifm_addr_t lo;
    ifm_addr_t hi;
  } ifm_trig_t;
  typedef struct packed {
    logic fire;
    logic preWarn;
    logic phone;
    logic fault;
  } ifm_buzreq_t;
  typedef enum logic [2:0] {
    BZ_NONE, BZ_FIRE, BZ_PREWARN, BZ_PHONE, BZ_INTLK, BZ_FAULT
  } ifm_buzsrc_t;
  typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_ON} ifm_phase_t;
endpackage : ifm_pkg

// ---- design/ifm_stamp_ram.sv ----
// timestamp store, one output and one input time per combination
`timescale 1ns/1ps
`include "ifm_consts.svh"
module ifm_stamp_ram
  import ifm_pkg::*;
(
  // clock
  input wire logic clk,
  // write side
  input wire logic [`IFM_IDX_W-1:0] wrAddr,
  input wire logic weOut,
  input wire logic weIn,
  input wire ifm_tod_t wrData,
  // read side
  input wire logic [`IFM_IDX_W-1:0] rdAddr,
  output ifm_stampw_t rdData
);
  ifm_tod_t memOut [0:`IFM_NCOMB-1];
  ifm_tod_t memIn [0:`IFM_NCOMB-1];

  // one write port per half, registered read
  always_ff @(posedge clk) begin
    if (weOut) begin
      memOut[wrAddr] <= wrData;
    end
    if (weIn) begin
      memIn[wrAddr] <= wrData;
    end
    rdData.pad <= '0;
    rdData.inAt <= memIn[rdAddr];
    rdData.outAt <= memOut[rdAddr];
  end
endmodule : ifm_stamp_ram

// ---- design/ifm_top.sv ----
// interlock combination supervisor: outputs, feedback check, indications
// Operation
// - one output, one feedback input per combination
// - 200 combinations here, 1000 per system
// - output activation type only steady or delayed
// - input counts only with trigger code 14
// - area 1-999, point 1-99 identify combination
// - output-only or input-only combinations allowed
// - buzzer 0.4/0.4 s, restarts on new input once silenced
// - buzzer priority fire, prewarn, phone, interlock, fault
// - latched output clears only on reset command or disable
// - fault if feedback late, 5-255 s window
// - supervision starts after activation delay ends
// - record output and input activation times
// - summary message only on empty display
// - any disabled output lights disablements LED
// - regional mode: three LEDs replace summary
// - manual activation held until reset command or disable, supervised
// - disabled output forced to normal state
// - zero address disables all outputs
// - zero address re-enables only global disables
// - other outputs query interlock conditions 15-18
// - conditions: area, point, any, range
`timescale 1ns/1ps
`include "ifm_consts.svh"
module ifm_top
  import ifm_pkg::*;
#(
  parameter int TICK_CYC = `IFM_TICK_MS * `IFM_NS_PER_MS / `IFM_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire ifm_req_t regReq,
  output logic [31:0] regRdata,
  // controlled equipment
  input wire logic [`IFM_NCOMB-1:0] ctrlExpr,
  input wire logic [`IFM_NCOMB-1:0] feedbackPin,
  output logic [`IFM_NCOMB-1:0] outDrive,
  // time of day and condition queries
  input wire ifm_tod_t timeOfDay,
  input wire ifm_trig_t trigQuery,
  output logic trigTrue,
  // buzzer
  input wire ifm_buzreq_t otherBuzz,
  output logic buzzerOn,
  output ifm_buzsrc_t buzzerSrc,
  // indications
  input wire logic displayBusy,
  output logic summaryMsg,
  output logic ledInAct,
  output logic ledOutAct,
  output logic ledOutDis,
  output logic ledDisablements,
  output logic faultAny
);
  logic rstMeta, rstSyncN;
  logic [`IFM_NCOMB-1:0] fbMeta, fbSync;
  logic [31:0] tickCnt;
  logic tick, secTick;
  logic [3:0] secCnt;
  logic [`IFM_IDX_W-1:0] selIdx, scanPtr;
  ifm_cfgb_t stage;
  ifm_ctrl_t ctrl;
  ifm_cmd_t cmd;
  logic cmdGo, cmdZero, cfgCommit, cfgOk, cfgErr, silence, intlkBuzz;
  ifm_cfga_t wrA;
  ifm_addr_t faultAddr, next_faultAddr;
  ifm_stampw_t stampRd;
  ifm_cfg_t cfgArr [0:`IFM_NCOMB-1];
  ifm_addr_t addrArr [0:`IFM_NCOMB-1];
  logic [`IFM_NCOMB-1:0] outOnV, inOnV, disV, faultV, faultSetV;
  logic [`IFM_NCOMB-1:0] buzRiseV, trigHitV, outPendV, inPendV;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // feedback contacts arrive from the field, asynchronous
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      fbMeta <= '0;
      fbSync <= '0;
    end else begin
      fbMeta <= feedbackPin;
      fbSync <= fbMeta;
    end
  end

  // 100 ms tick, seconds derived from it
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      tickCnt <= '0;
      tick <= 1'b0;
      secCnt <= 4'h0;
      secTick <= 1'b0;
    end else begin
      tick <= (tickCnt == 32'(TICK_CYC - 1));
      tickCnt <= (tickCnt == 32'(TICK_CYC - 1)) ? '0 : tickCnt + 32'h1;
      secTick <= tick && (secCnt == 4'(`IFM_SEC_TICKS - 1));
      if (tick) begin
        secCnt <= (secCnt == 4'(`IFM_SEC_TICKS - 1)) ? 4'h0 : secCnt + 4'h1;
      end
    end
  end

  // write decode; cfg fields checked before they are committed
  assign wrA = ifm_cfga_t'(regReq.wdata[30:0]); // top bit is spare
  assign cfgOk = (!wrA.hasOut || wrA.actType == `IFM_TYPE_STEADY
                  || wrA.actType == `IFM_TYPE_DELAY)
    && wrA.addr.area != 10'h000 && wrA.addr.area <= `IFM_AREA_MAX
    && wrA.addr.point != 7'h00 && wrA.addr.point <= `IFM_POINT_MAX
    && (!wrA.faultEn || stage.faultTime >= `IFM_FTIME_MIN);
  assign cfgCommit = regReq.wr && regReq.addr == `IFM_REG_CFGA && cfgOk;
  assign cmdZero = (cmd.addr == '0);

  // software-written registers
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      selIdx <= '0;
      stage <= '0;
      ctrl <= '0;
      cmd <= '0;
      cmdGo <= 1'b0;
      silence <= 1'b0;
      cfgErr <= 1'b0;
    end else begin
      cmdGo <= regReq.wr && regReq.addr == `IFM_REG_CMD;
      silence <= regReq.wr && regReq.addr == `IFM_REG_CTRL
                 && regReq.wdata[1];
      if (regReq.wr && regReq.addr == `IFM_REG_CTRL) begin
        ctrl.regional <= regReq.wdata[0];
      end
      if (regReq.wr && regReq.addr == `IFM_REG_SEL
          && regReq.wdata < 32'(`IFM_NCOMB)) begin
        selIdx <= regReq.wdata[`IFM_IDX_W-1:0]; // out-of-range ignored
      end
      if (regReq.wr && regReq.addr == `IFM_REG_CFGB) begin
        stage <= ifm_cfgb_t'(regReq.wdata);
      end
      if (regReq.wr && regReq.addr == `IFM_REG_CMD) begin
        cmd <= ifm_cmd_t'(regReq.wdata);
      end
      if (regReq.wr && regReq.addr == `IFM_REG_CFGA) begin
        cfgErr <= !cfgOk;
      end
    end
  end

  // per combination; each owns one output and one input
  for (genvar i = 0; i < `IFM_NCOMB; i++) begin : gEnt
    ifm_cfg_t cfg;
    ifm_phase_t phase;
    logic valid, manual, exprPrev, inPrev, onPrev, supOn;
    logic disInd, disGlob, fault, outPend, inPend;
    logic [7:0] dlyCnt, supCnt;
    logic hasOut, inOk, inAct, hit, dis, onRise, late;
    ifm_addr_t myAddr;

    assign myAddr = cfg.a.addr;
    assign hasOut = valid && cfg.a.hasOut;
    assign inOk = valid && cfg.a.hasIn
                  && cfg.a.trigSel == `IFM_TRIG_INTLK;
    assign inAct = inOk && fbSync[i];
    assign hit = cmdGo && valid && myAddr == cmd.addr;
    assign dis = disInd || disGlob;
    assign onRise = phase == PH_ON && !onPrev;
    assign late = supOn && !inAct && supCnt == cfg.b.faultTime;

    // configuration store
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        cfg <= '0;
        valid <= 1'b0;
      end else if (cfgCommit && selIdx == `IFM_IDX_W'(i)) begin
        cfg.a <= wrA;
        cfg.b <= stage;
        valid <= 1'b1;
      end
    end

    // disable bookkeeping: separate individual and global flags; an individual enable clears both
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        disInd <= 1'b0;
        disGlob <= 1'b0;
      end else if (cmdGo && cmd.op == `IFM_OP_DIS) begin
        if (cmdZero) begin
          disGlob <= 1'b1;
        end else if (hit) begin
          disInd <= 1'b1;
        end
      end else if (cmdGo && cmd.op == `IFM_OP_ENA) begin
        if (cmdZero) begin
          disGlob <= 1'b0;
        end else if (hit) begin
          disInd <= 1'b0;
          disGlob <= 1'b0;
        end
      end
    end

    // output sequence
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        phase <= PH_IDLE;
        manual <= 1'b0;
        exprPrev <= 1'b0;
        dlyCnt <= 8'h00;
      end else begin
        exprPrev <= ctrlExpr[i];
        if (!hasOut || dis) begin
          phase <= PH_IDLE;
          manual <= 1'b0;
        end else begin
          unique case (phase)
            PH_IDLE: begin
              dlyCnt <= 8'h00;
              if (hit && cmd.op == `IFM_OP_ACT) begin
                phase <= PH_ON;
                manual <= 1'b1;
              end else if (ctrlExpr[i] && !exprPrev) begin
                phase <= (cfg.a.actType == `IFM_TYPE_DELAY) ? PH_DELAY
                         : PH_ON;
              end
            end
            PH_DELAY: begin
              if (hit && cmd.op == `IFM_OP_ACT) begin
                phase <= PH_ON;
                manual <= 1'b1;
              end else if (!ctrlExpr[i]) begin
                phase <= PH_IDLE;
              end else if (dlyCnt == cfg.b.delayTime) begin
                phase <= PH_ON;
              end else if (secTick) begin
                dlyCnt <= dlyCnt + 8'h01;
              end
            end
            PH_ON: begin
              if (hit && cmd.op == `IFM_OP_RST) begin
                phase <= PH_IDLE;
                manual <= 1'b0;
              end else if (!manual && !cfg.a.latch && !ctrlExpr[i]) begin
                phase <= PH_IDLE;
              end
            end
          endcase
        end
      end
    end

    // feedback supervision from the moment the output is really on
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        onPrev <= 1'b0;
        supOn <= 1'b0;
        supCnt <= 8'h00;
        fault <= 1'b0;
      end else begin
        onPrev <= phase == PH_ON;
        if (onRise && cfg.a.faultEn && inOk) begin
          supOn <= 1'b1;
          supCnt <= 8'h00;
        end else if (inAct || phase != PH_ON || late) begin
          supOn <= 1'b0;
        end else if (supOn && secTick) begin
          supCnt <= supCnt + 8'h01;
        end
        if (phase == PH_IDLE || inAct) begin
          fault <= 1'b0;
        end
        if (late) begin
          fault <= 1'b1;
        end
      end
    end

    // timestamp requests, drained by the scanner; a new event wins
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        inPrev <= 1'b0;
        outPend <= 1'b0;
        inPend <= 1'b0;
      end else begin
        inPrev <= inAct;
        if (scanPtr == `IFM_IDX_W'(i)) begin
          outPend <= 1'b0;
          inPend <= 1'b0;
        end
        if (onRise) begin
          outPend <= 1'b1;
        end
        if (inAct && !inPrev) begin
          inPend <= 1'b1;
        end
      end
    end

    assign cfgArr[i] = cfg;
    assign addrArr[i] = myAddr;
    assign outOnV[i] = phase == PH_ON;
    assign inOnV[i] = inAct;
    assign disV[i] = hasOut && dis;
    assign faultV[i] = fault;
    assign faultSetV[i] = late;
    assign outPendV[i] = outPend;
    assign inPendV[i] = inPend;
    assign buzRiseV[i] = inAct && !inPrev && cfg.a.buzz;
    assign trigHitV[i] = inAct && (trigQuery.code == `IFM_COND_ANY
      || (trigQuery.code == `IFM_COND_AREA
          && myAddr.area == trigQuery.lo.area)
      || (trigQuery.code == `IFM_COND_POINT && myAddr == trigQuery.lo)
      || (trigQuery.code == `IFM_COND_RANGE && myAddr >= trigQuery.lo
          && myAddr <= trigQuery.hi));
  end

  // scanner visits one combination per cycle for timestamps
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      scanPtr <= '0;
    end else begin
      scanPtr <= (scanPtr == `IFM_IDX_W'(`IFM_NCOMB - 1)) ? '0
                 : scanPtr + `IFM_IDX_W'(1);
    end
  end

  ifm_stamp_ram uStamp (
    .clk(clk),
    .wrAddr(scanPtr),
    .weOut(outPendV[scanPtr]),
    .weIn(inPendV[scanPtr]),
    .wrData(timeOfDay),
    .rdAddr(selIdx),
    .rdData(stampRd)
  );

  // buzzer request: any new buzzer input re-arms, silence clears
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      intlkBuzz <= 1'b0;
    end else if (|buzRiseV) begin
      intlkBuzz <= 1'b1;
    end else if (silence) begin
      intlkBuzz <= 1'b0;
    end
  end

  ifm_buzzer uBuzz (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .tick(tick),
    .req(otherBuzz),
    .interlock(intlkBuzz),
    .regional(ctrl.regional),
    .buzzerOn(buzzerOn),
    .buzzerSrc(buzzerSrc)
  );

  // newest late feedback names its combination; lowest index wins ties
  always_comb begin
    next_faultAddr = faultAddr;
    for (int k = `IFM_NCOMB - 1; k >= 0; k--) begin
      if (faultSetV[k]) begin
        next_faultAddr = addrArr[k];
      end
    end
  end

  // indications, outputs and query answer
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      outDrive <= '0;
      faultAddr <= '0;
      faultAny <= 1'b0;
      trigTrue <= 1'b0;
      summaryMsg <= 1'b0;
      ledInAct <= 1'b0;
      ledOutAct <= 1'b0;
      ledOutDis <= 1'b0;
      ledDisablements <= 1'b0;
    end else begin
      outDrive <= outOnV & ~disV;
      faultAddr <= next_faultAddr;
      faultAny <= |faultV;
      trigTrue <= |trigHitV;
      summaryMsg <= !ctrl.regional && !displayBusy
                    && (|outOnV || |inOnV);
      ledInAct <= ctrl.regional && |inOnV;
      ledOutAct <= ctrl.regional && |outOnV;
      ledOutDis <= ctrl.regional && |disV;
      ledDisablements <= |disV;
    end
  end

  // register read, answer in the following cycle
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      regRdata <= '0;
    end else if (regReq.rd) begin
      unique case (regReq.addr)
        `IFM_REG_CTRL: regRdata <= {31'h0, ctrl.regional};
        `IFM_REG_SEL: regRdata <= {24'h0, selIdx};
        `IFM_REG_CFGA: regRdata <= {1'b0, cfgArr[selIdx].a};
        `IFM_REG_CFGB: regRdata <= cfgArr[selIdx].b;
        `IFM_REG_CMD: regRdata <= cmd;
        `IFM_REG_STAT: regRdata <= {26'h0, cfgErr, |faultV,
          faultV[selIdx], disV[selIdx], inOnV[selIdx], outOnV[selIdx]};
        `IFM_REG_STAMP: regRdata <= stampRd;
        `IFM_REG_FLT: regRdata <= {15'h0, faultAddr};
        default: regRdata <= '0;
      endcase
    end
  end
endmodule : ifm_top

// ---- tb/ifm_equip.sv ----
// equipment model: closes its contact a while after being driven
`timescale 1ns/1ps
module ifm_equip #(
  parameter int N = 200,
  parameter int LAG = 6
) (
  // clock
  input wire logic clk,
  // drive from the monitor, and contacts that never answer
  input wire logic [N-1:0] drive,
  input wire logic [N-1:0] dead,
  // feedback contact
  output logic [N-1:0] contact
);
  int cnt [N];
  // contact opens at once on release, so no stale level is left
  initial contact = '0;
  always @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      cnt[i] <= drive[i] ? cnt[i] + 1 : 0;
      contact[i] <= drive[i] && !dead[i] && cnt[i] >= LAG;
    end
  end
endmodule : ifm_equip

// ---- tb/ifm_props.sv ----
// port assertions for the interlock monitor
`timescale 1ns/1ps
`include "ifm_consts.svh"
module ifm_props
  import ifm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire ifm_req_t regReq,
  input wire logic [`IFM_NCOMB-1:0] feedbackPin,
  input wire logic [`IFM_NCOMB-1:0] outDrive,
  input wire ifm_buzreq_t otherBuzz,
  input wire ifm_buzsrc_t buzzerSrc,
  input wire logic buzzerOn,
  input wire logic displayBusy,
  input wire logic summaryMsg,
  input wire logic ledInAct,
  input wire logic ledOutAct,
  input wire logic ledOutDis,
  input wire logic ledDisablements,
  input wire ifm_trig_t trigQuery,
  input wire logic trigTrue
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // command word that disables every output
  wire gDis = regReq.wr && regReq.addr == `IFM_REG_CMD &&
    regReq.wdata[19:0] == {`IFM_OP_DIS, 17'h0};
  // buzzer arbitration and sounding
  fire_first_a: assert property (
    otherBuzz.fire [*4] |-> buzzerSrc == BZ_FIRE)
    else $error("fire request not on top");
  fire_steady_a: assert property (
    buzzerSrc == BZ_FIRE [*2] |-> buzzerOn)
    else $error("fire buzzer not steady");
  // indications
  busy_quiet_a: assert property (
    displayBusy [*2] |-> !summaryMsg)
    else $error("summary over a busy display");
  led_excl_a: assert property (
    summaryMsg |-> !(ledInAct || ledOutAct || ledOutDis))
    else $error("summary and leds together");
  dis_led_a: assert property (
    $rose(ledOutDis) |-> ##[0:2] ledDisablements)
    else $error("disablements led missing");
  in_led_a: assert property (
    feedbackPin == '0 [*5] |-> !ledInAct)
    else $error("input led without input");
  // outputs and conditions
  all_off_a: assert property (
    gDis |-> ##3 outDrive == '0)
    else $error("global disable left an output on");
  any_idle_a: assert property (
    feedbackPin == '0 [*6] ##0 trigQuery.code == `IFM_COND_ANY
      |=> !trigTrue)
    else $error("any-input condition without input");
  // main scenarios
  cover property (gDis);
  cover property (buzzerSrc == BZ_INTLK && buzzerOn);
  cover property ($rose(summaryMsg));
endmodule : ifm_props

bind ifm_top ifm_props u_props (.clk, .rst_n, .regReq, .feedbackPin,
  .outDrive, .otherBuzz, .buzzerSrc, .buzzerOn, .displayBusy,
  .summaryMsg, .ledInAct, .ledOutAct, .ledOutDis, .ledDisablements,
  .trigQuery, .trigTrue);

// ---- tb/interlock_feedback_monitor_test.sv ----
// self-checking bench for the interlock monitor
`timescale 1ns/1ps
`include "ifm_consts.svh"
module interlock_feedback_monitor_test
  import ifm_pkg::*;
;
  localparam logic [16:0] A0 = {10'h005, 7'h01};
  localparam logic [16:0] A1 = {10'h006, 7'h02};
  typedef struct packed {
    logic [16:0] ad;
    logic [2:0] ty;
    logic [7:0] ft;
    logic err;
  } ifm_row_t;
  typedef struct packed {
    ifm_trig_t q;
    logic e;
  } ifm_qrow_t;
  logic clk = 0, rst_n = 0, displayBusy = 0;
  logic trigTrue, buzzerOn, summaryMsg, ledInAct, ledOutAct, ledOutDis;
  logic ledDisablements, faultAny;
  logic [31:0] regRdata, d;
  logic [199:0] ctrlExpr = '0, feedbackPin, outDrive, dead = 200'h2;
  ifm_req_t regReq = '0;
  ifm_tod_t timeOfDay = {5'h0c, 6'h1e};
  ifm_trig_t trigQuery = '0;
  ifm_buzreq_t otherBuzz = '0;
  ifm_buzsrc_t buzzerSrc;
  int error_cnt = 0, total_checks = 0, cycles = 0, n, t0;
  ifm_row_t rows [10] = '{
    '{{10'h003, 7'h03}, 3'h0, 8'h05, 1'b0},
    '{{10'h003, 7'h03}, 3'h3, 8'h05, 1'b0},
    '{{10'h003, 7'h03}, 3'h1, 8'h05, 1'b1},
    '{{10'h003, 7'h03}, 3'h7, 8'h05, 1'b1},
    '{{10'h000, 7'h03}, 3'h0, 8'h05, 1'b1},
    '{{10'h3e8, 7'h03}, 3'h0, 8'h05, 1'b1},
    '{{10'h003, 7'h00}, 3'h0, 8'h05, 1'b1},
    '{{10'h003, 7'h64}, 3'h0, 8'h05, 1'b1},
    '{{10'h003, 7'h03}, 3'h0, 8'h04, 1'b1},
    '{{10'h3e7, 7'h63}, 3'h0, 8'hff, 1'b0}};
  ifm_qrow_t qs [7] = '{
    '{'{5'h0f, A0, A0}, 1'b1}, '{'{5'h0f, A1, A1}, 1'b0},
    '{'{5'h10, A0, A0}, 1'b1}, '{'{5'h10, A0 + 17'h1, A0}, 1'b0},
    '{'{5'h11, A0, A0}, 1'b1}, '{'{5'h12, A0 - 17'h1, A0}, 1'b1},
    '{'{5'h12, A1, {10'h3e7, 7'h63}}, 1'b0}};
  ifm_buzreq_t bz [4] = '{4'b1111, 4'b0111, 4'b0011, 4'b0001};
  ifm_buzsrc_t bzs [4] = '{BZ_FIRE, BZ_PREWARN, BZ_INTLK, BZ_INTLK};

  // design and the equipment it controls
  ifm_top #(.TICK_CYC(20)) u_dut (.clk, .rst_n, .regReq, .regRdata,
    .ctrlExpr, .feedbackPin, .outDrive, .timeOfDay, .trigQuery,
    .trigTrue, .otherBuzz, .buzzerOn, .buzzerSrc, .displayBusy,
    .summaryMsg, .ledInAct, .ledOutAct, .ledOutDis, .ledDisablements,
    .faultAny);
  ifm_equip #(.LAG(6)) u_equip (.clk, .drive(outDrive), .dead,
    .contact(feedbackPin));

  // clock and hang guard; a second is 200 cycles here
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk) regReq <= '{a, w, 1'b1, 1'b0};
    @(posedge clk) regReq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk) regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  function automatic logic [31:0] mkA(logic [16:0] a, logic [2:0] t,
      logic [2:0] o);
    return {2'b00, o, `IFM_TRIG_INTLK, t, 2'b11, a};
  endfunction : mkA
  function automatic logic [31:0] cm(logic [2:0] o, logic [16:0] a);
    return {12'h0, o, a};
  endfunction : cm

  // main sequence
  initial begin
    cyc(10);
    chk(outDrive !== '0, 0);
    chk(buzzerSrc, BZ_NONE);
    @(posedge clk) rst_n <= 1'b1;
    cyc(3);
    rd(8'h20);
    chk(d, 0);
    // each row follows a good entry, so a stuck error flag shows
    wr(`IFM_REG_SEL, 2);
    foreach (rows[i]) begin
      wr(`IFM_REG_CFGB, 5);
      wr(`IFM_REG_CFGA, mkA(rows[9].ad, 3'h0, 3'b100));
      wr(`IFM_REG_CFGB, rows[i].ft);
      wr(`IFM_REG_CFGA, mkA(rows[i].ad, rows[i].ty, 3'b100));
      rd(`IFM_REG_STAT);
      chk(d[5], rows[i].err);
    end
    wr(`IFM_REG_SEL, 0);
    wr(`IFM_REG_CFGB, 5);
    wr(`IFM_REG_CFGA, mkA(A0, 3'h0, 3'b110));
    wr(`IFM_REG_SEL, 1);
    wr(`IFM_REG_CFGB, {8'h03, 8'h05});
    wr(`IFM_REG_CFGA, mkA(A1, 3'h3, 3'b101));
    @(posedge clk) ctrlExpr <= 200'h3;
    t0 = cycles;
    cyc(3);
    chk(outDrive[1:0], 2'b01);
    cyc(20);
    foreach (qs[i]) begin
      @(posedge clk) trigQuery <= qs[i].q;
      cyc(2);
      chk(trigTrue, qs[i].e);
    end
    chk(buzzerSrc, BZ_INTLK);
    n = 0;
    repeat (320) begin
      cyc(1);
      n += buzzerOn;
    end
    chk(n, 160);
    foreach (bz[i]) begin
      @(posedge clk) otherBuzz <= bz[i];
      cyc(4);
      chk(buzzerSrc, bzs[i]);
    end
    wr(`IFM_REG_CTRL, 2);
    cyc(4);
    chk(buzzerSrc, BZ_FAULT);
    @(posedge clk) otherBuzz <= 4'b0010;
    wr(`IFM_REG_CTRL, 1);
    cyc(4);
    chk(buzzerSrc, BZ_PHONE);
    chk({ledInAct, ledOutAct, summaryMsg}, 3'b110);
    wr(`IFM_REG_CTRL, 0);
    cyc(4);
    chk(summaryMsg, 1);
    @(posedge clk) displayBusy <= 1'b1;
    cyc(3);
    chk(summaryMsg, 0);
    wr(`IFM_REG_SEL, 0);
    rd(`IFM_REG_STAMP);
    chk(d[21:0], {timeOfDay, timeOfDay});
    @(posedge clk) ctrlExpr[0] <= 1'b0;
    cyc(4);
    chk(outDrive[0], 0);
    // delayed output: supervision runs only after the delay
    n = 0;
    while (outDrive[1] !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk(cycles - t0 >= 400 && cycles - t0 <= 610, 1);
    n = 0;
    while (faultAny !== 1'b1 && n < 1400) begin
      cyc(1);
      n++;
    end
    chk(n >= 790 && n <= 1210, 1);
    rd(`IFM_REG_FLT);
    chk(d[16:0], A1);
    @(posedge clk) ctrlExpr[1] <= 1'b0;
    cyc(5);
    chk(outDrive[1], 1);
    wr(`IFM_REG_CMD, cm(`IFM_OP_RST, A1));
    cyc(3);
    chk(outDrive[1], 0);
    // manual start, then individual and global disables
    wr(`IFM_REG_CMD, cm(`IFM_OP_ACT, A0));
    cyc(3);
    chk(outDrive[0], 1);
    cyc(20);
    chk(buzzerSrc, BZ_INTLK);
    // regional mode, so the disabled-output led shows as well
    wr(`IFM_REG_CTRL, 1);
    wr(`IFM_REG_CMD, cm(`IFM_OP_DIS, A0));
    cyc(3);
    chk(outDrive[0], 0);
    chk({ledDisablements, ledOutDis}, 2'b11);
    wr(`IFM_REG_CMD, cm(`IFM_OP_DIS, 0));
    wr(`IFM_REG_CMD, cm(`IFM_OP_ACT, A1));
    cyc(3);
    chk(outDrive[1], 0);
    wr(`IFM_REG_CMD, cm(`IFM_OP_ENA, 0));
    wr(`IFM_REG_CMD, cm(`IFM_OP_ACT, A1));
    wr(`IFM_REG_CMD, cm(`IFM_OP_ACT, A0));
    cyc(3);
    chk(outDrive[1:0], 2'b10);
    wr(`IFM_REG_CMD, cm(`IFM_OP_ENA, A0));
    cyc(4);
    chk({ledDisablements, ledOutDis}, 2'b00);
    stop_test();
  end
endmodule : interlock_feedback_monitor_test
